// ---- verilog/sec_eeprom.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Sample input on rising clock while selected.
// - After opcode, shift more or drive falling-edge data.
// - All fields travel most significant bit first.
// - Decode set and clear write latch opcodes.
// - Decode array read and write with address.
// - Identification read/write when select bit zero.
// - Select bit one means lock status or lock.
// - Power-up leaves latch cleared, nothing protected.
// - Latch clears after clear, status or array write.
// - While busy only status read is accepted.
// - Status read repeats status byte while selected.
// - Status write needs latch, no hardware protection.
// - Status write keeps protect bits, applied at completion.
// - Protect enable falls only with pin high.
// - Array read streams and wraps to zero.
// - Rising select ends array read anytime.
// - Array write wraps within one 64-byte page.
// - Protected blocks never written; latch needed elsewhere.
// - Identification read auto-increments within page.
// - Identification read rejected while busy; then standby.
// - Status layout: busy, latch, two protect, enable.
// - Protect codes select quarter, half, or all.
// - Hardware protection is pin low and enable set.
// - All status bits read one during writes.
module sec_eeprom #(
  parameter logic [sec_pkg::WR_CNT_W-1:0] WRITE_CYCLES = sec_pkg::WRITE_CYCLES // Write time.
) (
  input wire logic ref_clk, // Core clock, 100 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic sck, // Serial clock from the master.
  input wire logic cs_n, // Chip select, active low.
  input wire logic si, // Serial data in.
  input wire logic wp_n, // Write-protect pin, active low.
  output logic so, // Serial data out.
  output logic so_oe // Output enable of the data out pin.
);

  // Link control state; cleared by chip select high so every frame starts clean.
  typedef struct packed {
    sec_pkg::sec_lstate_t st; // Link state.
    logic [3:0] cnt; // Bit counter.
    logic [7:0] sh; // Input shift register.
    sec_pkg::sec_kind_t kind; // Decoded instruction.
    logic arm; // A complete launchable sequence was seen.
    logic [7:0] stat1; // Status synchroniser, first stage.
    logic [7:0] stat2; // Status synchroniser, second stage.
  } sec_link_t;

  // Link payload; not cleared by chip select, because the core may still be
  // committing it while a status read frame runs.
  typedef struct packed {
    logic [sec_pkg::ARR_AW-1:0] addr; // Working address.
    logic [sec_pkg::PAGE_BYTES-1:0] mask; // Page bytes supplied in this write.
    logic [7:0] sdata; // Last status-write data byte.
    sec_pkg::sec_kind_t kind; // Decoded kind, kept after select rises.
    logic arm; // Launch flag, kept after select rises.
  } sec_pay_t;

  // Falling-edge output stage.
  typedef struct packed {
    logic so; // Data bit on the pin.
    logic oe; // Pin driven.
  } sec_out_t;

  // Core state on the reference clock.
  typedef struct packed {
    sec_pkg::sec_cstate_t st; // Core state.
    logic cs1; // Chip select synchroniser, first stage.
    logic cs2; // Chip select synchroniser, second stage.
    logic cs3; // Previous synchronised chip select.
    logic wp1; // Write-protect synchroniser, first stage.
    logic wp2; // Write-protect synchroniser, second stage.
    logic arm1; // Launch synchroniser, first stage.
    logic arm2; // Launch synchroniser, second stage.
    logic [1:0] settle; // Settle counter.
    logic [sec_pkg::PAGE_AW:0] idx; // Commit index.
    logic [sec_pkg::WR_CNT_W-1:0] tmr; // Write-cycle timer.
    sec_pkg::sec_kind_t ckind; // Operation being committed.
    logic wel; // Write latch.
    logic [1:0] bp; // Block protect bits.
    logic protect_enable_bit; // Protect enable bit.
    logic busy; // Write cycle running.
    logic [1:0] new_bp; // Pending block protect.
    logic new_protect_enable_bit; // Pending protect enable.
    logic [7:0] status; // Status byte as presented to the link.
  } sec_core_t;

  localparam sec_link_t LINK_RST = '{st: sec_pkg::L_CMD, kind: sec_pkg::K_NONE, default: '0};
  localparam sec_core_t CORE_RST = '{st: sec_pkg::C_IDLE, ckind: sec_pkg::K_NONE,
                                     cs1: 1'b1, cs2: 1'b1, cs3: 1'b1, default: '0};

  sec_link_t l_q, l_d; // Link control register and next value.
  sec_pay_t p_q, p_d; // Payload register and next value.
  sec_out_t o_q, o_d; // Output register and next value.
  sec_core_t c_q, c_d; // Core register and next value.

  logic [7:0] arr_mem [sec_pkg::ARR_BYTES]; // Array storage.
  logic [7:0] id_mem [sec_pkg::PAGE_BYTES]; // Identification page storage.
  logic [7:0] page_buf [sec_pkg::PAGE_BYTES]; // Write page buffer, link side.

  logic pb_we; // Page buffer write strobe.
  logic [7:0] rx_byte; // Byte completed on this edge.
  logic [15:0] rx_addr; // Address completed on this edge.
  logic link_busy; // Busy as seen by the link.
  logic [7:0] tx_byte; // Byte being shifted out.
  logic mem_we; // Array or identification write strobe.
  logic [sec_pkg::ARR_AW-1:0] mem_addr; // Commit target address.
  logic hw_prot; // Hardware write protection active.
  logic page_prot; // Committed page lies in a protected block.

  // Protection check of an array address against the block-protect code.
  function automatic logic sec_protected(input logic [1:0] bp,
                                         input logic [sec_pkg::ARR_AW-1:0] a);
    logic hit;
    hit = 1'b1;
    case (bp)
      sec_pkg::BP_NONE: hit = 1'b0;
      sec_pkg::BP_QUARTER: hit = (a >= sec_pkg::PROT_QUARTER_BASE);
      sec_pkg::BP_HALF: hit = (a >= sec_pkg::PROT_HALF_BASE);
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Link next state: bits are taken on the rising serial clock.
  always_comb begin
    l_d = l_q;
    p_d = p_q;
    pb_we = 1'b0;
    l_d.arm = 1'b0; // Any further bit cancels a pending launch.
    l_d.stat1 = c_q.status;
    l_d.stat2 = l_q.stat1;
    link_busy = l_q.stat2[sec_pkg::ST_BUSY];
    rx_byte = {l_q.sh[6:0], si}; // Shift in, first bit ends on top.
    rx_addr = {1'b0, p_q.addr, si};
    case (l_q.st)
      sec_pkg::L_CMD: begin
        l_d.sh = rx_byte;
        l_d.cnt = l_q.cnt + 4'h1;
        if (l_q.cnt == sec_pkg::BYTE_LAST) begin
          l_d.cnt = '0;
          l_d.st = sec_pkg::L_IGNORE; // Undefined codes leave the output off.
          if (rx_byte[7:4] == sec_pkg::OP_SPACE_MAIN) begin
            case (rx_byte[2:0]) // Bit 3 is ignored.
              sec_pkg::OP_SET_LATCH: begin
                l_d.kind = sec_pkg::K_SETL;
                l_d.arm = 1'b1;
              end
              sec_pkg::OP_CLR_LATCH: begin
                l_d.kind = sec_pkg::K_CLRL;
                l_d.arm = 1'b1;
              end
              sec_pkg::OP_STAT_READ: begin
                l_d.kind = sec_pkg::K_STR;
                l_d.st = sec_pkg::L_RDATA;
              end
              sec_pkg::OP_STAT_WRITE: begin
                l_d.kind = sec_pkg::K_STW;
                l_d.st = sec_pkg::L_WDATA;
              end
              sec_pkg::OP_READ: begin
                l_d.kind = sec_pkg::K_ARR;
                l_d.st = sec_pkg::L_ADDR;
              end
              sec_pkg::OP_WRITE: begin
                l_d.kind = sec_pkg::K_ARW;
                l_d.st = sec_pkg::L_ADDR;
              end
              default: l_d.kind = sec_pkg::K_NONE;
            endcase
          end else if (rx_byte[7:4] == sec_pkg::OP_SPACE_ID) begin
            if (rx_byte[2:0] == sec_pkg::OP_READ) begin
              l_d.kind = sec_pkg::K_IDR;
              l_d.st = sec_pkg::L_ADDR;
            end else if (rx_byte[2:0] == sec_pkg::OP_WRITE) begin
              l_d.kind = sec_pkg::K_IDW;
              l_d.st = sec_pkg::L_ADDR;
            end
          end
          // During a write cycle everything but status read is dropped.
          if (link_busy && !(l_d.kind == sec_pkg::K_STR)) begin
            l_d.st = sec_pkg::L_IGNORE;
            l_d.arm = 1'b0;
          end
        end
      end
      sec_pkg::L_ADDR: begin
        p_d.addr = rx_addr[sec_pkg::ARR_AW-1:0]; // Top two bits fall off.
        l_d.cnt = l_q.cnt + 4'h1;
        if (l_q.cnt == sec_pkg::ADDR_LAST) begin
          l_d.cnt = '0;
          l_d.st = sec_pkg::L_RDATA;
          if (l_q.kind == sec_pkg::K_ARW || l_q.kind == sec_pkg::K_IDW) begin
            l_d.st = sec_pkg::L_WDATA;
            p_d.mask = '0;
          end
          if (rx_addr[sec_pkg::ID_SEL_BIT]) begin
            if (l_q.kind == sec_pkg::K_IDR) begin
              l_d.kind = sec_pkg::K_LSR;
            end else if (l_q.kind == sec_pkg::K_IDW) begin
              l_d.kind = sec_pkg::K_LOCK;
            end
          end
        end
      end
      sec_pkg::L_WDATA: begin
        l_d.sh = rx_byte;
        l_d.cnt = l_q.cnt + 4'h1;
        if (l_q.cnt == sec_pkg::BYTE_LAST) begin
          l_d.cnt = '0;
          l_d.arm = 1'b1; // Launch only on a whole data byte.
          if (l_q.kind == sec_pkg::K_STW) begin
            p_d.sdata = rx_byte;
          end else begin
            pb_we = 1'b1;
            p_d.mask[p_q.addr[sec_pkg::PAGE_AW-1:0]] = 1'b1;
            // The in-page address wraps; page bits stay put.
            p_d.addr[sec_pkg::PAGE_AW-1:0] = p_q.addr[sec_pkg::PAGE_AW-1:0] + 6'h01;
          end
        end
      end
      sec_pkg::L_RDATA: begin
        l_d.cnt = {1'b0, l_q.cnt[2:0] + 3'h1};
        if (l_q.cnt == sec_pkg::BYTE_LAST) begin
          l_d.cnt = '0;
          if (l_q.kind == sec_pkg::K_ARR) begin
            p_d.addr = p_q.addr + 14'h0001; // Wraps from the top to zero.
          end else if (l_q.kind == sec_pkg::K_IDR) begin
            p_d.addr[sec_pkg::PAGE_AW-1:0] =
              p_q.addr[sec_pkg::PAGE_AW-1:0] + 6'h01;
          end
        end
      end
      default: l_d.cnt = l_q.cnt; // Ignored frame: wait for chip select.
    endcase
    // Select high clears the link register at once, so the core would only
    // ever see an empty kind; these copies stay put until the next frame.
    p_d.kind = l_d.kind;
    p_d.arm = l_d.arm;
  end

  // Link control registers; chip select high ends any frame.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      l_q <= LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  // Payload and page buffer on the rising serial clock.
  always_ff @(posedge sck) begin
    p_q <= p_d;
    if (pb_we) begin
      page_buf[p_q.addr[sec_pkg::PAGE_AW-1:0]] <= rx_byte;
    end
  end

  // Byte to send; the core never writes memory while a read is accepted.
  always_comb begin
    case (l_q.kind)
      sec_pkg::K_STR: tx_byte = l_q.stat2; // Repeats for as long as selected.
      sec_pkg::K_ARR: tx_byte = arr_mem[p_q.addr];
      sec_pkg::K_IDR: tx_byte = id_mem[p_q.addr[sec_pkg::PAGE_AW-1:0]];
      default: tx_byte = 8'h00; // Lock status: the page is never locked here.
    endcase
    o_d.so = tx_byte[3'h7 - l_q.cnt[2:0]]; // Top bit first.
    o_d.oe = (l_q.st == sec_pkg::L_RDATA); // Off for ignored frames.
  end

  // Output changes on the falling serial clock.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      o_q <= '0;
    end else begin
      o_q <= o_d;
    end
  end

  assign so = o_q.so;
  assign so_oe = o_q.oe;

  // Core next state: launches operations after chip select rises.
  always_comb begin
    c_d = c_q;
    c_d.cs1 = cs_n;
    c_d.cs2 = c_q.cs1;
    c_d.cs3 = c_q.cs2;
    c_d.wp1 = wp_n;
    c_d.wp2 = c_q.wp1;
    c_d.arm1 = p_q.arm;
    c_d.arm2 = c_q.arm1;
    hw_prot = c_q.protect_enable_bit && !c_q.wp2;
    mem_addr = {p_q.addr[sec_pkg::ARR_AW-1:sec_pkg::PAGE_AW],
                c_q.idx[sec_pkg::PAGE_AW-1:0]};
    page_prot = sec_protected(c_q.bp, mem_addr);
    mem_we = 1'b0;
    case (c_q.st)
      sec_pkg::C_IDLE: begin
        if (c_q.cs2 && !c_q.cs3) begin
          c_d.st = sec_pkg::C_SETTLE; // Frame ended; launch point.
          c_d.settle = '0;
        end
      end
      sec_pkg::C_SETTLE: begin
        // The link is frozen; its kind and payload are read once settled.
        c_d.settle = c_q.settle + 2'h1;
        if (c_q.settle == sec_pkg::SETTLE_LAST) begin
          c_d.st = sec_pkg::C_IDLE;
          c_d.idx = '0;
          c_d.tmr = '0;
          c_d.ckind = p_q.kind;
          if (c_q.arm2) begin
            case (p_q.kind)
              sec_pkg::K_SETL: c_d.wel = 1'b1;
              sec_pkg::K_CLRL: c_d.wel = 1'b0;
              sec_pkg::K_STW: begin
                if (c_q.wel && !hw_prot) begin
                  c_d.busy = 1'b1;
                  c_d.st = sec_pkg::C_WAIT;
                  c_d.new_bp = {p_q.sdata[sec_pkg::ST_BP_HI], p_q.sdata[sec_pkg::ST_BP_LO]};
                  // Enable may drop only with the pin high.
                  c_d.new_protect_enable_bit = p_q.sdata[sec_pkg::ST_PROT_EN] ||
                                 (c_q.protect_enable_bit && !c_q.wp2);
                end
              end
              sec_pkg::K_ARW, sec_pkg::K_IDW: begin
                if (c_q.wel) begin
                  c_d.busy = 1'b1;
                  c_d.st = sec_pkg::C_COMMIT;
                end
              end
              default: c_d.st = sec_pkg::C_IDLE;
            endcase
          end
        end
      end
      sec_pkg::C_COMMIT: begin
        // Only bytes supplied in this frame are written, one per cycle.
        mem_we = p_q.mask[c_q.idx[sec_pkg::PAGE_AW-1:0]] &&
                 !(c_q.ckind == sec_pkg::K_ARW && page_prot);
        c_d.idx = c_q.idx + 7'h01;
        if (c_q.idx[sec_pkg::PAGE_AW-1:0] == 6'h3F) begin
          c_d.st = sec_pkg::C_WAIT;
        end
      end
      sec_pkg::C_WAIT: begin
        c_d.tmr = c_q.tmr + 20'h00001;
        if (c_q.tmr == WRITE_CYCLES - 20'h00001) begin
          c_d.st = sec_pkg::C_IDLE; // Back to standby.
          c_d.busy = 1'b0;
          c_d.wel = 1'b0;
          if (c_q.ckind == sec_pkg::K_STW) begin
            c_d.bp = c_q.new_bp; // Applied only at completion.
            c_d.protect_enable_bit = c_q.new_protect_enable_bit;
          end
        end
      end
      default: c_d.st = sec_pkg::C_IDLE;
    endcase
    c_d.status = '0; // Bits 4 to 6 are not kept.
    c_d.status[sec_pkg::ST_BUSY] = c_d.busy;
    c_d.status[sec_pkg::ST_LATCH] = c_d.wel;
    c_d.status[sec_pkg::ST_BP_LO] = c_d.bp[0];
    c_d.status[sec_pkg::ST_BP_HI] = c_d.bp[1];
    c_d.status[sec_pkg::ST_PROT_EN] = c_d.protect_enable_bit;
    if (c_d.busy) begin
      c_d.status = sec_pkg::ST_ALL_ONES;
    end
  end

  // Core registers; reset leaves everything write-disabled.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      c_q <= CORE_RST;
    end else begin
      c_q <= c_d;
    end
  end

  // Memory commit from the frozen page buffer.
  always_ff @(posedge ref_clk) begin
    if (mem_we && c_q.ckind == sec_pkg::K_ARW) begin
      arr_mem[mem_addr] <= page_buf[c_q.idx[sec_pkg::PAGE_AW-1:0]];
    end
    if (mem_we && c_q.ckind == sec_pkg::K_IDW) begin
      id_mem[c_q.idx[sec_pkg::PAGE_AW-1:0]] <= page_buf[c_q.idx[sec_pkg::PAGE_AW-1:0]];
    end
  end

endmodule

// ---- verilog/sec_pkg.sv ----
// Shared constants for the serial EEPROM command logic.
package sec_pkg;

  // Instruction byte fields: upper nibble selects the space, bit 3 is ignored.
  localparam logic [3:0] OP_SPACE_MAIN = 4'h0; // Main array and status space.
  localparam logic [3:0] OP_SPACE_ID = 4'h8; // Identification page space.
  localparam logic [2:0] OP_SET_LATCH = 3'h6; // set_write_latch_cmd.
  localparam logic [2:0] OP_CLR_LATCH = 3'h4; // clear_write_latch_cmd.
  localparam logic [2:0] OP_STAT_READ = 3'h5; // status_read_cmd.
  localparam logic [2:0] OP_STAT_WRITE = 3'h1; // status_write_cmd.
  localparam logic [2:0] OP_READ = 3'h3; // Array or identification read.
  localparam logic [2:0] OP_WRITE = 3'h2; // Array or identification write.

  // Status register bit positions.
  localparam int ST_BUSY = 0; // Busy flag.
  localparam int ST_LATCH = 1; // Write latch.
  localparam int ST_BP_LO = 2; // block_protect_lo.
  localparam int ST_BP_HI = 3; // block_protect_hi.
  localparam int ST_PROT_EN = 7; // protect_enable_bit.
  localparam logic [7:0] ST_ALL_ONES = 8'hFF; // Reading during a write cycle.

  // Address geometry.
  localparam int ARR_AW = 14; // Array address width, upper bits ignored.
  localparam int PAGE_AW = 6; // In-page address width.
  localparam int PAGE_BYTES = 64; // Bytes in one page.
  localparam int ARR_BYTES = 16384; // Bytes in the array.
  localparam int ID_SEL_BIT = 10; // Position of id_space_select_bit.
  localparam logic [ARR_AW-1:0] PROT_QUARTER_BASE = 14'h3000; // Level 1 start.
  localparam logic [ARR_AW-1:0] PROT_HALF_BASE = 14'h2000; // Level 2 start.
  localparam logic [1:0] BP_NONE = 2'h0; // No block protected.
  localparam logic [1:0] BP_QUARTER = 2'h1; // Upper quarter protected.
  localparam logic [1:0] BP_HALF = 2'h2; // Upper half protected.

  // Link counters.
  localparam logic [3:0] BYTE_LAST = 4'h7; // Last bit of a byte.
  localparam logic [3:0] ADDR_LAST = 4'hF; // Last bit of the address.
  localparam logic [1:0] SETTLE_LAST = 2'h3; // Last settle count; four cycles let crossed data settle.

  // Self-timed write cycle.
  localparam int WRITE_TIME_NS = 5000000; // Longest write cycle, 5 ms.
  localparam int CLK_PERIOD_NS = 10; // Core clock period.
  localparam int WR_CNT_W = 20; // Width of the write-cycle counter.
  localparam logic [WR_CNT_W-1:0] WRITE_CYCLES =
    WR_CNT_W'(WRITE_TIME_NS / CLK_PERIOD_NS); // Rounded down.

  // Decoded instruction kinds, carried from the link to the core.
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_SETL = 4'h1, K_CLRL = 4'h2, K_STR = 4'h3, K_STW = 4'h4,
    K_ARR = 4'h5, K_ARW = 4'h6, K_IDR = 4'h7, K_IDW = 4'h8, K_LSR = 4'h9,
    K_LOCK = 4'hA
  } sec_kind_t;

  // Link states, one-hot.
  typedef enum logic [4:0] {
    L_CMD = 5'h01, L_ADDR = 5'h02, L_WDATA = 5'h04, L_RDATA = 5'h08, L_IGNORE = 5'h10
  } sec_lstate_t;

  // Core states, one-hot.
  typedef enum logic [3:0] {
    C_IDLE = 4'h1, C_SETTLE = 4'h2, C_COMMIT = 4'h4, C_WAIT = 4'h8
  } sec_cstate_t;

endpackage

// ---- tb/sec_eeprom_checker.sv ----
`timescale 1ns/10ps
// Watches the serial pins of the EEPROM command logic.
module sec_eeprom_checker (
  input wire logic ref_clk, // Core clock.
  input wire logic sys_rst, // Core reset.
  input wire logic sck, // Serial clock.
  input wire logic cs_n, // Chip select, active low.
  input wire logic si, // Serial data in.
  input wire logic wp_n, // Write-protect pin.
  input wire logic so, // Serial data out.
  input wire logic so_oe // Output enable.
);
  logic [9:0] cnt_q; // Rising edges seen in this frame, saturating.
  logic [7:0] op_q; // Opcode shifted in.
  logic is_st, is_rd, is_wr, is_bad; // Opcode classes.
  // Select high clears the frame state at once, as the link logic does.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_q <= 10'h000;
      op_q <= 8'h00;
    end else begin
      if (cnt_q != 10'h3FF) begin
        cnt_q <= cnt_q + 10'h001;
      end
      if (cnt_q < 10'h008) begin
        op_q <= {op_q[6:0], si};
      end
    end
  end
  // Bit 3 is left out of every class, since the device ignores it.
  always_comb begin
    is_st = op_q[7:4] == 4'h0 && op_q[2:0] == 3'h5;
    is_rd = (op_q[7:4] == 4'h0 || op_q[7:4] == 4'h8) && op_q[2:0] == 3'h3;
    // Identification write and lock share one code; neither drives the output.
    is_wr = op_q[7:4] == 4'h0 && op_q[2:0] inside {3'h6, 3'h4, 3'h1, 3'h2}
      || op_q[7:4] == 4'h8 && op_q[2:0] == 3'h2;
    is_bad = !(is_st || is_rd || is_wr);
  end
  idle_off_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_n |-> !so_oe && !so) else $error("output driven while deselected");
  cmd_quiet_a: assert property (@(posedge sck) disable iff (cs_n)
    cnt_q < 10'h008 |-> !so_oe) else $error("output during opcode");
  status_drive_a: assert property (@(posedge sck) disable iff (cs_n)
    cnt_q >= 10'h008 && is_st |-> so_oe) else $error("status not driven");
  bad_quiet_a: assert property (@(posedge sck) disable iff (cs_n)
    cnt_q >= 10'h008 && is_bad |-> !so_oe) else $error("undefined opcode drove");
  write_quiet_a: assert property (@(posedge sck) disable iff (cs_n)
    is_wr |-> !so_oe) else $error("write opcode drove output");
  drive_start_a: assert property (@(posedge sck) disable iff (cs_n)
    $rose(so_oe) |-> is_st && cnt_q == 10'h008 || is_rd && cnt_q == 10'h018)
    else $error("output started at wrong bit");
  status_rep_a: assert property (@(posedge sck) disable iff (cs_n)
    is_st && cnt_q >= 10'h010 |-> so == $past(so, 8)) else $error("status not repeated");
  status_fill_a: assert property (@(posedge sck) disable iff (cs_n)
    is_st && cnt_q >= 10'h00F && cnt_q[2:0] == 3'h7 |-> so == $past(so, 6))
    else $error("status filler bits wrong");
  oe_hold_a: assert property (@(posedge sck) disable iff (cs_n)
    cnt_q != 10'h000 && $past(so_oe) |-> so_oe) else $error("output dropped in frame");
  status_c: cover property (@(posedge sck) is_st && cnt_q == 10'h010);
  read_c: cover property (@(posedge sck) is_rd && so_oe && cnt_q == 10'h018);
  bad_c: cover property (@(posedge sck) is_bad && cnt_q == 10'h009);
endmodule

// ---- tb/sec_spi_master.sv ----
`timescale 1ns/10ps
// Serial master: mode 0, clock idles low and runs only inside frames.
module sec_spi_master (
  output logic sck, // Serial clock, 12 ns period.
  output logic cs_n, // Chip select, active low.
  output logic si, // Serial data to the device.
  input wire logic so, // Serial data from the device.
  input wire logic so_oe, // Device drives so.
  output logic [7:0] rx_byte, // Last byte read back.
  output logic rx_tgl // Toggles once per byte read back.
);
  logic [7:0] tx_q[$]; // Bytes to send in the next frame.
  // A short select pulse at start clears the device's link and output stage.
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    rx_byte = 8'h00;
    rx_tgl = 1'b0;
    #1 cs_n = 1'b1;
  end
  // A byte is reported only if the device drove all eight of its bits.
  task automatic run(input int nrd);
    logic [7:0] b;
    logic [7:0] sh;
    logic ok;
    cs_n = 1'b0;
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        si = b[i];
        #6 sck = 1'b1;
        #6 sck = 1'b0;
      end
    end
    for (int k = 0; k < nrd; k++) begin
      ok = 1'b1;
      for (int i = 7; i >= 0; i--) begin
        si = ~si; // Input is meaningless now, so it keeps moving.
        #6 sck = 1'b1;
        sh[i] = so;
        ok = ok & so_oe;
        #6 sck = 1'b0;
      end
      if (ok === 1'b1) begin
        rx_byte = sh;
        rx_tgl = ~rx_tgl;
      end
    end
    #3 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
// Self-checking bench; frames go through the master model.
module testbench;
  localparam logic [sec_pkg::WR_CNT_W-1:0] WC = 20'h00032; // Short write cycle.
  logic ref_clk = 1'b0; // Core clock.
  logic sys_rst = 1'b1; // Core reset.
  logic wp_n = 1'b1; // Write-protect pin.
  logic sck, cs_n, si, so, so_oe, rx_tgl; // Link pins.
  logic [7:0] rx_byte; // Byte seen by the master.
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first.
  logic [7:0] dq[$]; // Data bytes of the next frame.
  logic [7:0] d[6]; // Random payload.
  logic [7:0] bad[4] = '{8'h07, 8'h40, 8'h87, 8'h00}; // Undefined opcodes.
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 ref_clk = ~ref_clk;
  sec_eeprom #(.WRITE_CYCLES(WC)) u_sec_eeprom (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
  sec_spi_master u_sec_spi_master (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .rx_byte(rx_byte), .rx_tgl(rx_tgl));
  task automatic fail(input string m);
    num_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) fail("read byte mismatch");
  endtask
  // Each byte read back retires the oldest expectation.
  always @(rx_tgl) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) fail("unexpected read byte");
      else cmp_byte(rx_byte, exp_q.pop_front());
    end
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      tally_and_finish();
    end
  end
  // One frame, then enough core cycles for the select rise to settle.
  task automatic cmd(input logic [7:0] op, input logic [15:0] a, input bit wa, input int n);
    @(negedge ref_clk);
    u_sec_spi_master.tx_q.push_back(op);
    if (wa) u_sec_spi_master.tx_q = {u_sec_spi_master.tx_q, a[15:8], a[7:0]};
    while (dq.size() > 0) u_sec_spi_master.tx_q.push_back(dq.pop_front());
    u_sec_spi_master.run(n);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic stat(input logic [7:0] e, input int n);
    repeat (n) exp_q.push_back(e);
    cmd(8'h05, 16'h0000, 1'b0, n);
  endtask
  task automatic wr_wait();
    repeat (WC + 80) @(posedge ref_clk);
  endtask
  initial begin
    void'($urandom(58));
    foreach (d[i]) d[i] = 8'($urandom());
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    stat(8'h00, 2);
    cmd(8'h0E, 16'h0000, 1'b0, 0);
    stat(8'h02, 1);
    cmd(8'h0C, 16'h0000, 1'b0, 0);
    stat(8'h00, 1);
    // Page write that wraps, with refused reads while busy.
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{d[0], d[1], d[2], d[3]};
    cmd(8'h02, 16'h3FFE, 1'b1, 0);
    stat(8'hFF, 1);
    cmd(8'h03, 16'h0000, 1'b1, 2);
    cmd(8'h83, 16'h0000, 1'b1, 1);
    wr_wait();
    stat(8'h00, 1);
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{d[4]};
    cmd(8'h02, 16'hC000, 1'b1, 0);
    wr_wait();
    exp_q = {exp_q, d[0], d[1], d[4]};
    cmd(8'h03, 16'h3FFE, 1'b1, 3);
    exp_q = {exp_q, d[2], d[3]};
    cmd(8'h03, 16'hFFC0, 1'b1, 2);
    // Block protection of the upper quarter.
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{8'h74};
    cmd(8'h01, 16'h0000, 1'b0, 0);
    wr_wait();
    stat(8'h04, 1);
    // A write into the protected quarter still runs a cycle and clears the latch.
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{~d[0]};
    cmd(8'h02, 16'h3FFE, 1'b1, 0);
    wr_wait();
    stat(8'h04, 1);
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{d[5]};
    cmd(8'h02, 16'h2FFF, 1'b1, 0);
    wr_wait();
    exp_q.push_back(d[5]);
    cmd(8'h03, 16'h2FFF, 1'b1, 1);
    exp_q.push_back(d[0]);
    cmd(8'h03, 16'h3FFE, 1'b1, 1);
    // Hardware protection.
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{8'h84};
    cmd(8'h01, 16'h0000, 1'b0, 0);
    wr_wait();
    stat(8'h84, 1);
    @(negedge ref_clk) wp_n = 1'b0;
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{8'h00};
    cmd(8'h01, 16'h0000, 1'b0, 0);
    stat(8'h86, 1);
    @(negedge ref_clk) wp_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    dq = '{8'h00};
    cmd(8'h01, 16'h0000, 1'b0, 0);
    wr_wait();
    stat(8'h00, 1);
    foreach (bad[i]) cmd(bad[i], 16'h0000, 1'b1, 2);
    // Identification page, kept inside the page.
    cmd(8'h06, 16'h0000, 1'b0, 0);
    dq = '{d[1], d[2]};
    cmd(8'h82, 16'h003E, 1'b1, 0);
    wr_wait();
    exp_q = {exp_q, d[1], d[2]};
    cmd(8'h8B, 16'hFBBE, 1'b1, 2);
    exp_q = {exp_q, 8'h00, 8'h00};
    cmd(8'h83, 16'h0400, 1'b1, 2);
    if (exp_q.size() != 0) fail("expected bytes never read");
    tally_and_finish();
  end
endmodule
bind sec_eeprom sec_eeprom_checker u_sec_eeprom_checker (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe));
